// ---- verilog/fpuei_pkg.sv ----
// Package for the exception and initialization unit of the numeric coprocessor.
// Assumes a single hclk domain and an AHB-Lite register port.
package fpuei_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_TAG = 8'h08;
   localparam logic [7:0] OFS_INSTR_PTR = 8'h0c;
   localparam logic [7:0] OFS_DATA_PTR = 8'h10;
   localparam logic [7:0] OFS_COMMAND = 8'h14;
   // Command register bits
   localparam int CMD_INIT_BIT = 0;
   localparam int CMD_CLEAR_BIT = 1;
   // Reset and init values
   localparam logic [15:0] CONTROL_INIT = 16'h037f;
   localparam logic [15:0] TAG_INIT = 16'hffff;
   localparam logic [2:0] TOP_INIT = 3'h0;
   localparam logic [5:0] ALL_MASKED = 6'h3f;
   // Exception bit positions, shared by flags and masks
   localparam int EX_INVALID = 0;
   localparam int EX_DENORM = 1;
   localparam int EX_ZDIV = 2;
   localparam int EX_OVF = 3;
   localparam int EX_UNF = 4;
   localparam int EX_PREC = 5;
   // Status word fields
   localparam int SW_STACK_FAULT = 6;
   localparam int SW_ERR_SUMMARY = 7;
   localparam int SW_C0 = 8;
   localparam int SW_C1 = 9;
   localparam int SW_C2 = 10;
   localparam int SW_TOP_LSB = 11;
   localparam int SW_C3 = 14;
   localparam int SW_BUSY = 15;
   // Control word fields
   localparam int CW_PC_LSB = 8;
   localparam int CW_RC_LSB = 10;
   localparam int CW_INF_CTRL = 12;
   localparam logic [1:0] RC_NEAREST = 2'h0;
   localparam logic [1:0] RC_DOWN = 2'h1;
   localparam logic [1:0] RC_UP = 2'h2;
   localparam logic [1:0] RC_CHOP = 2'h3;
   localparam logic [1:0] TAG_EMPTY = 2'h3;

   typedef enum logic [3:0] {
      OP_ARITH, OP_DIV, OP_COMPARE, OP_INT_STORE, OP_BCD_STORE, OP_LOAD_SD,
      OP_LOAD_EXT, OP_EXTRACT, OP_SCALE, OP_PREM, OP_ENV_STORE, OP_ENV_LOAD
   } fpuei_op_e;

   typedef enum logic [2:0] {
      CLS_ZERO, CLS_NORMAL, CLS_DENORM, CLS_INF, CLS_QNAN, CLS_SNAN, CLS_UNSUP
   } fpuei_cls_e;

   typedef enum logic [3:0] {
      RESP_NONE, RESP_QNAN, RESP_INT_INDEF, RESP_BCD_INDEF, RESP_NORMALIZE, RESP_INF,
      RESP_LARGEST, RESP_DENORM_ZERO, RESP_ROUNDED, RESP_ZERO, RESP_NEG_INF_ST1, RESP_TRAP
   } fpuei_resp_e;

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DONE} fpuei_state_e;
   typedef enum logic [1:0] {SW_NONE, SW_INIT, SW_CLEAR, SW_LDCW} fpuei_swop_e;
endpackage

// ---- verilog/fpuei_top.sv ----
// Exception detection, masked response, reporting and init state of the coprocessor.
// Assumes datapath classifies operands and results; software reaches registers over AHB-Lite.
// Contract
// - Six exceptions, precedence invalid, denormal, zero divide, overflow, underflow, inexact.
// - Invalid covers sNaN, unsupported, indeterminate, stack faults; masked gives NaN or indefinite.
// - Masked denormal operand is normalized and processing continues.
// - Zero divisor with finite nonzero dividend raises zero divide; masked gives infinity.
// - Masked overflow returns largest finite or infinity per rounding mode.
// - Masked underflow gives denormal or zero; flag only on accuracy loss.
// - Inexact result is rounded, precision flagged, continues when masked.
// - Unmasked exception sets its flag, error summary and the error output.
// - Address of faulting instruction and memory operand kept for the handler.
// - Reset or no-wait init loads control word 037f.
// - Init clears bit 12; infinity is always affine regardless.
// - Init clears flags and busy bit, stack top zero.
// - Condition codes cleared on reset, init and incomplete partial remainder.
// - Init loads tag word ffff, all registers empty.
// - Software tag writes only create empty tags; others follow real contents.
// - Pseudo and unnormal encodings are unsupported, raising invalid operation.
// - Extracting zero raises zero divide, leaves negative infinity in register one.
// - Only quiet NaNs made; qNaN raises invalid only on compare, integer, BCD store.
// - Scale by infinity: zero invalid, finite gives signed zero or infinity.
// - Single/double denormal load raises denormal; extended load never does.
// - Error output mirrors summary, changes only while busy, cleared by listed ops.
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fpuei_top
   import fpuei_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic instr_valid,
   output logic instr_ready,
   input wire fpuei_op_e instr_op,
   input wire logic [31:0] instr_addr,
   input wire logic [31:0] oper_addr,
   input wire logic has_mem_oper,
   input wire fpuei_cls_e opa_class,
   input wire fpuei_cls_e opb_class,
   input wire logic opa_sign,
   input wire logic stack_overflow,
   input wire logic stack_underflow,
   input wire logic indeterminate,
   input wire logic res_too_big,
   input wire logic res_tiny,
   input wire logic res_denorm_loses,
   input wire logic res_inexact,
   input wire logic res_sign,
   input wire logic prem_incomplete,
   input wire logic [3:0] cc_in,
   input wire logic [2:0] top_in,
   input wire logic [15:0] env_control,
   input wire logic [15:0] env_status,
   input wire logic [15:0] tag_live,
   input wire logic [7:0] reg_written,
   output logic resp_valid,
   output fpuei_resp_e resp_kind,
   output logic resp_sign,
   output logic [1:0] round_mode,
   output logic [1:0] precision_ctrl,
   output logic busy_n,
   output logic error_n
);
   fpuei_state_e state;
   fpuei_swop_e sw_pend;
   logic [15:0] sw_data;
   fpuei_swop_e cur_sw;
   logic [15:0] cur_sw_data;
   logic [15:0] control;
   logic [5:0] flags;
   logic stack_fault;
   logic err_summary;
   logic [3:0] cc;
   logic [2:0] top;
   logic [7:0] forced_empty;
   logic [31:0] instr_ptr;
   logic [31:0] data_ptr;
   // Captured instruction
   fpuei_op_e c_op;
   fpuei_cls_e c_a;
   fpuei_cls_e c_b;
   logic c_asign, c_rsign, c_sovf, c_sunf, c_indet, c_big, c_tiny, c_loses, c_inex;
   logic c_prem_inc, c_mem;
   logic [3:0] c_cc;
   logic [2:0] c_top;
   logic [31:0] c_iaddr, c_oaddr;
   logic [15:0] c_env_cw, c_env_sw;
   // AHB address phase
   logic dp_active, dp_write;
   logic [7:0] dp_addr;
   logic wr_stall;
   logic [5:0] raw_ex;
   logic [5:0] set_ex;
   fpuei_resp_e next_resp;
   logic next_err;
   logic [15:0] status_word;
   logic [15:0] tag_word;

   function automatic logic is_finite(input fpuei_cls_e c);
      is_finite = (c == CLS_ZERO) || (c == CLS_NORMAL) || (c == CLS_DENORM);
   endfunction

   function automatic logic is_nz_finite(input fpuei_cls_e c);
      is_nz_finite = (c == CLS_NORMAL) || (c == CLS_DENORM);
   endfunction

   // Raw exception vector in mask bit order
   function automatic logic [5:0] classify(
      input fpuei_op_e op, input fpuei_cls_e a, input fpuei_cls_e b,
      input logic sovf, input logic sunf, input logic indet,
      input logic big, input logic tiny, input logic inex);
      logic qnan_traps;
      logic inval;
      logic den;
      qnan_traps = (op == OP_COMPARE) || (op == OP_INT_STORE) || (op == OP_BCD_STORE);
      inval = (a == CLS_SNAN) || (b == CLS_SNAN)
         || (a == CLS_UNSUP) || (b == CLS_UNSUP)
         || indet || sovf || sunf
         || (qnan_traps && ((a == CLS_QNAN) || (b == CLS_QNAN)))
         || (op == OP_SCALE && a == CLS_ZERO && b == CLS_INF);
      den = (op != OP_LOAD_EXT)
         && ((a == CLS_DENORM) || (op != OP_LOAD_SD && b == CLS_DENORM));
      classify = '0;
      classify[EX_INVALID] = inval;
      classify[EX_DENORM] = den;
      classify[EX_ZDIV] = (op == OP_DIV && b == CLS_ZERO && is_nz_finite(a))
         || (op == OP_EXTRACT && a == CLS_ZERO);
      classify[EX_OVF] = big;
      classify[EX_UNF] = tiny;
      classify[EX_PREC] = inex;
   endfunction

   // Masked overflow answer follows rounding direction
   function automatic fpuei_resp_e ovf_resp(input logic [1:0] rc, input logic neg);
      unique case (rc)
         RC_NEAREST: ovf_resp = RESP_INF;
         RC_DOWN: ovf_resp = neg ? RESP_INF : RESP_LARGEST;
         RC_UP: ovf_resp = neg ? RESP_LARGEST : RESP_INF;
         RC_CHOP: ovf_resp = RESP_LARGEST;
      endcase
   endfunction

   // Bit 12 is stored but never steers arithmetic: infinity is affine
   assign round_mode = control[CW_RC_LSB +: 2];
   assign precision_ctrl = control[CW_PC_LSB +: 2];

   always_comb begin
      raw_ex = classify(c_op, c_a, c_b, c_sovf, c_sunf, c_indet, c_big, c_tiny, c_inex);
      set_ex = raw_ex;
      // Masked underflow flags only with loss of accuracy
      set_ex[EX_UNF] = raw_ex[EX_UNF] && (!control[EX_UNF] || c_loses);
      next_err = |(set_ex & ~control[5:0]);
      next_resp = RESP_NONE;
      // Highest-precedence raised exception decides the answer
      if (set_ex[EX_INVALID]) begin
         if (!control[EX_INVALID])
            next_resp = RESP_TRAP;
         else if (c_op == OP_INT_STORE)
            next_resp = RESP_INT_INDEF;
         else if (c_op == OP_BCD_STORE)
            next_resp = RESP_BCD_INDEF;
         else
            next_resp = RESP_QNAN;
      end else if (set_ex[EX_DENORM]) begin
         next_resp = control[EX_DENORM] ? RESP_NORMALIZE : RESP_TRAP;
      end else if (set_ex[EX_ZDIV]) begin
         if (!control[EX_ZDIV])
            next_resp = RESP_TRAP;
         else
            next_resp = (c_op == OP_EXTRACT) ? RESP_NEG_INF_ST1 : RESP_INF;
      end else if (set_ex[EX_OVF]) begin
         next_resp = control[EX_OVF] ? ovf_resp(round_mode, c_rsign) : RESP_TRAP;
      end else if (raw_ex[EX_UNF]) begin
         next_resp = control[EX_UNF] ? RESP_DENORM_ZERO : RESP_TRAP;
      end else if (set_ex[EX_PREC]) begin
         next_resp = control[EX_PREC] ? RESP_ROUNDED : RESP_TRAP;
      end else if (c_op == OP_SCALE && is_finite(c_a) && c_b == CLS_INF) begin
         next_resp = c_rsign ? RESP_ZERO : RESP_INF;
      end
   end

   // AHB-Lite slave: zero wait, stalls only a second queued software op
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_active <= 1'b0;
         dp_write <= 1'b0;
         dp_addr <= 8'h00;
      end else if (hreadyout) begin
         dp_active <= hsel && htrans[1] && hready;
         dp_write <= hwrite;
         dp_addr <= haddr[7:0];
      end
   end

   assign wr_stall = dp_active && dp_write && (sw_pend != SW_NONE)
      && (dp_addr == OFS_CONTROL || dp_addr == OFS_COMMAND);
   assign hreadyout = !wr_stall;
   assign hresp = 1'b0;

   // Non-empty tags come from real register contents
   always_comb begin
      for (int i = 0; i < 8; i++)
         tag_word[2*i +: 2] = forced_empty[i] ? TAG_EMPTY : tag_live[2*i +: 2];
   end

   always_comb begin
      status_word = '0;
      status_word[5:0] = flags;
      status_word[SW_STACK_FAULT] = stack_fault;
      status_word[SW_ERR_SUMMARY] = err_summary;
      status_word[SW_C0] = cc[0];
      status_word[SW_C1] = cc[1];
      status_word[SW_C2] = cc[2];
      status_word[SW_C3] = cc[3];
      status_word[SW_TOP_LSB +: 3] = top;
      status_word[SW_BUSY] = (state != ST_IDLE);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (hsel && htrans[1] && hready && !hwrite && hreadyout) begin
         unique case (haddr[7:0])
            OFS_CONTROL: hrdata <= {16'h0000, control};
            OFS_STATUS: hrdata <= {16'h0000, status_word};
            OFS_TAG: hrdata <= {16'h0000, tag_word};
            OFS_INSTR_PTR: hrdata <= instr_ptr;
            OFS_DATA_PTR: hrdata <= data_ptr;
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // Software ops queue until the unit is idle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sw_pend <= SW_NONE;
         sw_data <= 16'h0000;
      end else if (dp_active && dp_write && !wr_stall && dp_addr == OFS_CONTROL) begin
         sw_pend <= SW_LDCW;
         sw_data <= hwdata[15:0];
      end else if (dp_active && dp_write && !wr_stall && dp_addr == OFS_COMMAND
         && hwdata[CMD_INIT_BIT]) begin
         sw_pend <= SW_INIT;
      end else if (dp_active && dp_write && !wr_stall && dp_addr == OFS_COMMAND
         && hwdata[CMD_CLEAR_BIT]) begin
         sw_pend <= SW_CLEAR;
      end else if (state == ST_IDLE) begin
         sw_pend <= SW_NONE;
      end
   end

   assign instr_ready = (state == ST_IDLE) && (sw_pend == SW_NONE);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         state <= ST_IDLE;
      else begin
         unique case (state)
            ST_IDLE: if (sw_pend != SW_NONE || instr_valid) state <= ST_EXEC;
            ST_EXEC: state <= ST_DONE;
            ST_DONE: state <= ST_IDLE;
         endcase
      end
   end

   assign busy_n = (state == ST_IDLE);
   assign error_n = !err_summary;

   // Capture the op being started
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cur_sw <= SW_NONE;
         cur_sw_data <= 16'h0000;
         c_op <= OP_ARITH;
         c_a <= CLS_ZERO;
         c_b <= CLS_ZERO;
         {c_asign, c_rsign, c_sovf, c_sunf, c_indet, c_big, c_tiny, c_loses} <= 8'h00;
         {c_inex, c_prem_inc, c_mem} <= 3'h0;
         c_cc <= 4'h0;
         c_top <= 3'h0;
         c_iaddr <= 32'h0000_0000;
         c_oaddr <= 32'h0000_0000;
         c_env_cw <= 16'h0000;
         c_env_sw <= 16'h0000;
      end else if (state == ST_IDLE) begin
         cur_sw <= sw_pend;
         cur_sw_data <= sw_data;
         c_op <= instr_op;
         c_a <= opa_class;
         c_b <= opb_class;
         {c_asign, c_rsign, c_sovf, c_sunf} <= {opa_sign, res_sign, stack_overflow,
            stack_underflow};
         {c_indet, c_big, c_tiny, c_loses} <= {indeterminate, res_too_big, res_tiny,
            res_denorm_loses};
         {c_inex, c_prem_inc, c_mem} <= {res_inexact, prem_incomplete, has_mem_oper};
         c_cc <= cc_in;
         c_top <= top_in;
         c_iaddr <= instr_addr;
         c_oaddr <= oper_addr;
         c_env_cw <= env_control;
         c_env_sw <= env_status;
      end
   end

   // Architectural state; all changes land at the end of the busy exec cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         control <= CONTROL_INIT;
         flags <= 6'h00;
         stack_fault <= 1'b0;
         err_summary <= 1'b0;
         cc <= 4'h0;
         top <= TOP_INIT;
      end else if (state == ST_EXEC) begin
         unique case (cur_sw)
            SW_INIT: begin
               control <= CONTROL_INIT;
               flags <= 6'h00;
               stack_fault <= 1'b0;
               err_summary <= 1'b0;
               cc <= 4'h0;
               top <= TOP_INIT;
            end
            SW_CLEAR: begin
               flags <= 6'h00;
               stack_fault <= 1'b0;
               err_summary <= 1'b0;
            end
            SW_LDCW: begin
               control <= cur_sw_data;
               err_summary <= |(flags & ~cur_sw_data[5:0]);
            end
            SW_NONE: begin
               if (c_op == OP_ENV_STORE) begin
                  // Storing the environment masks everything
                  control[5:0] <= ALL_MASKED;
                  err_summary <= 1'b0;
               end else if (c_op == OP_ENV_LOAD) begin
                  control <= c_env_cw;
                  flags <= c_env_sw[5:0];
                  stack_fault <= c_env_sw[SW_STACK_FAULT];
                  cc <= {c_env_sw[SW_C3], c_env_sw[SW_C2], c_env_sw[SW_C1], c_env_sw[SW_C0]};
                  top <= c_env_sw[SW_TOP_LSB +: 3];
                  err_summary <= |(c_env_sw[5:0] & ~c_env_cw[5:0]);
               end else begin
                  flags <= flags | set_ex;
                  if (c_sovf || c_sunf)
                     stack_fault <= 1'b1;
                  if (next_err)
                     err_summary <= 1'b1;
                  cc <= (c_op == OP_PREM && c_prem_inc) ? 4'h0 : c_cc;
                  top <= c_top;
               end
            end
         endcase
      end
   end

   // Pointers of the last escape kept for the handler
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         instr_ptr <= 32'h0000_0000;
         data_ptr <= 32'h0000_0000;
      end else if (state == ST_EXEC && cur_sw == SW_NONE
         && c_op != OP_ENV_STORE && c_op != OP_ENV_LOAD) begin
         instr_ptr <= c_iaddr;
         if (c_mem)
            data_ptr <= c_oaddr;
      end
   end

   // Software may only force empty; datapath writes reveal real tags
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         forced_empty <= 8'hff;
      else if (state == ST_EXEC && cur_sw == SW_INIT)
         forced_empty <= 8'hff;
      else if (dp_active && dp_write && dp_addr == OFS_TAG) begin
         for (int i = 0; i < 8; i++)
            forced_empty[i] <= (hwdata[2*i +: 2] == TAG_EMPTY);
      end else
         forced_empty <= forced_empty & ~reg_written;
   end

   // Response to the datapath, one pulse per instruction
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         resp_valid <= 1'b0;
         resp_kind <= RESP_NONE;
         resp_sign <= 1'b0;
      end else begin
         resp_valid <= (state == ST_EXEC) && (cur_sw == SW_NONE);
         if (state == ST_EXEC && cur_sw == SW_NONE) begin
            resp_kind <= next_resp;
            resp_sign <= (next_resp == RESP_NEG_INF_ST1) ? 1'b1
               : (next_resp == RESP_ZERO || next_resp == RESP_INF) && c_op == OP_SCALE
               ? c_asign : c_rsign;
         end
      end
   end
endmodule
`default_nettype wire

// ---- dv/fpuei_host.sv ----
// Host CPU model: hands escape instructions to the unit and traps on a pending error.
// Assumes the bench sets the operand lines and pulses issue for one cycle.
`timescale 1ns/1ps
`default_nettype none
module fpuei_host (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic issue,
   input wire logic instr_ready,
   input wire logic error_n,
   output logic instr_valid,
   output logic trap16
);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         instr_valid <= 1'b0;
         trap16 <= 1'b0;
      end else begin
         trap16 <= issue && !error_n;
         if (issue && error_n) begin
            instr_valid <= 1'b1;
         end else if (instr_ready) begin
            instr_valid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ---- dv/fpuei_top_chk.sv ----
// Checker for the exception unit: handshake, busy window and error output timing.
// Assumes it is bound to fpuei_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module fpuei_top_chk
   import fpuei_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic instr_valid,
   input wire logic instr_ready,
   input wire logic resp_valid,
   input wire logic [1:0] round_mode,
   input wire logic [1:0] precision_ctrl,
   input wire logic busy_n,
   input wire logic error_n
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence taken_s;
      instr_valid && instr_ready;
   endsequence
   sequence exec_s;
      !busy_n ##1 (!busy_n && resp_valid) ##1 busy_n;
   endsequence
   instr_walk_a:
   assert property (taken_s |=> exec_s) else $error("instruction walk broken");
   err_busy_a:
   assert property ($changed(error_n) |-> $past(busy_n) == 1'b0) else $error("error moved idle");
   err_cause_a:
   assert property ($fell(error_n) |-> resp_valid) else $error("error without response");
   reset_out_a:
   assert property ($rose(hresetn) |-> busy_n && error_n && round_mode == RC_NEAREST
      && precision_ctrl == 2'h3) else $error("bad state after reset");
   resp_pulse_a:
   assert property (resp_valid |=> !resp_valid) else $error("response longer than a cycle");
   busy_block_a:
   assert property (!busy_n |-> !instr_ready) else $error("ready while busy");
   busy_span_a:
   assert property ($fell(busy_n) |-> ##[1:3] busy_n) else $error("busy too long");
   read_nowait_a:
   assert property (hsel && htrans[1] && !hwrite && hready |=> hreadyout)
      else $error("read stalled");
   resp_okay_a:
   assert property (hresp == 1'b0) else $error("response not okay");
endmodule
bind fpuei_top fpuei_top_chk chk_u (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
   .hreadyout, .hresp, .instr_valid, .instr_ready, .resp_valid, .round_mode, .precision_ctrl,
   .busy_n, .error_n);
`default_nettype wire

// ---- dv/test_fpu_exception_and_init.sv ----
// Bench for the exception unit: reset state, masked and unmasked exceptions, tags, codes.
// Assumes fpuei_top, its checker and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_fpu_exception_and_init;
   import fpuei_pkg::*;
   logic hclk, hresetn, hsel, hwrite, issue, trap16, instr_valid, instr_ready, has_mem_oper;
   logic opa_sign, res_sign, stack_overflow, stack_underflow, indeterminate, res_too_big;
   logic res_tiny, res_denorm_loses, res_inexact, prem_incomplete, hreadyout, hresp;
   logic resp_valid, resp_sign, busy_n, error_n;
   logic [1:0] htrans, round_mode, precision_ctrl;
   logic [2:0] hsize, top_in;
   logic [3:0] cc_in;
   logic [7:0] reg_written;
   logic [15:0] env_control, env_status, tag_live;
   logic [31:0] haddr, hwdata, hrdata, instr_addr, oper_addr, rd;
   fpuei_op_e instr_op;
   fpuei_cls_e opa_class, opb_class;
   fpuei_resp_e resp_kind;
   int n_errors = 0;
   int checked = 0;
   fpuei_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .instr_valid, .instr_ready, .instr_op,
      .instr_addr, .oper_addr, .has_mem_oper, .opa_class, .opb_class, .opa_sign,
      .stack_overflow, .stack_underflow, .indeterminate, .res_too_big, .res_tiny,
      .res_denorm_loses, .res_inexact, .res_sign, .prem_incomplete, .cc_in, .top_in,
      .env_control, .env_status, .tag_live, .reg_written, .resp_valid, .resp_kind,
      .resp_sign, .round_mode, .precision_ctrl, .busy_n, .error_n);
   fpuei_host host_u (.hclk, .hresetn, .issue, .instr_ready, .error_n, .instr_valid, .trap16);
   task stop_test;
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         n_errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      hsel <= 1'b0;
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e);
      ahb(a, 1'b0, 32'h0);
      chk(rd, e);
   endtask
   task swop(input logic [7:0] a, input logic [31:0] d);
      ahb(a, 1'b1, d);
      repeat (5) @(posedge hclk);
   endtask
   task ex(input fpuei_op_e o, input fpuei_cls_e a, b, input logic [7:0] q, input fpuei_resp_e k);
      int n;
      n = 0;
      @(posedge hclk);
      instr_op <= o;
      opa_class <= a;
      opb_class <= b;
      {prem_incomplete, res_inexact, res_denorm_loses, res_tiny, res_too_big, indeterminate,
         stack_underflow, stack_overflow} <= q;
      issue <= 1'b1;
      @(posedge hclk);
      issue <= 1'b0;
      do @(posedge hclk); while (resp_valid !== 1'b1 && ++n < 20);
      chk({resp_valid, resp_kind}, {1'b1, k});
   endtask
   task exf(input fpuei_op_e o, input fpuei_cls_e a, b, input logic [7:0] q,
      input fpuei_resp_e k, input logic [7:0] f);
      ex(o, a, b, q, k);
      ahb(OFS_STATUS, 1'b0, 32'h0);
      chk(rd[7:0], f);
      swop(OFS_COMMAND, 32'h2);
   endtask
   task s_reset;
      rdc(OFS_CONTROL, 32'h037f);
      rdc(OFS_TAG, 32'hffff);
      ahb(OFS_STATUS, 1'b1, 32'hffff);
      rdc(OFS_STATUS, 32'h0);
      rdc(8'h20, 32'h0);
      chk(error_n, 1'b1);
      swop(OFS_COMMAND, 32'h1);
   endtask
   task s_masked;
      opa_sign <= 1'b1;
      exf(OP_ARITH, CLS_SNAN, CLS_NORMAL, 8'h00, RESP_QNAN, 8'h01);
      exf(OP_ARITH, CLS_NORMAL, CLS_NORMAL, 8'h01, RESP_QNAN, 8'h41);
      exf(OP_ARITH, CLS_NORMAL, CLS_NORMAL, 8'h04, RESP_QNAN, 8'h01);
      exf(OP_INT_STORE, CLS_QNAN, CLS_NORMAL, 8'h00, RESP_INT_INDEF, 8'h01);
      exf(OP_BCD_STORE, CLS_QNAN, CLS_NORMAL, 8'h00, RESP_BCD_INDEF, 8'h01);
      exf(OP_ARITH, CLS_QNAN, CLS_NORMAL, 8'h00, RESP_NONE, 8'h00);
      exf(OP_ARITH, CLS_UNSUP, CLS_NORMAL, 8'h00, RESP_QNAN, 8'h01);
      exf(OP_ARITH, CLS_DENORM, CLS_NORMAL, 8'h00, RESP_NORMALIZE, 8'h02);
      exf(OP_DIV, CLS_NORMAL, CLS_ZERO, 8'h00, RESP_INF, 8'h04);
      exf(OP_ARITH, CLS_NORMAL, CLS_NORMAL, 8'h08, RESP_INF, 8'h08);
      exf(OP_ARITH, CLS_NORMAL, CLS_NORMAL, 8'h30, RESP_DENORM_ZERO, 8'h10);
      exf(OP_ARITH, CLS_NORMAL, CLS_NORMAL, 8'h10, RESP_DENORM_ZERO, 8'h00);
      exf(OP_ARITH, CLS_NORMAL, CLS_NORMAL, 8'h40, RESP_ROUNDED, 8'h20);
      exf(OP_EXTRACT, CLS_ZERO, CLS_NORMAL, 8'h00, RESP_NEG_INF_ST1, 8'h04);
      exf(OP_SCALE, CLS_ZERO, CLS_INF, 8'h00, RESP_QNAN, 8'h01);
      res_sign <= 1'b1;
      exf(OP_SCALE, CLS_NORMAL, CLS_INF, 8'h00, RESP_ZERO, 8'h00);
      chk(resp_sign, 1'b1);
      exf(OP_LOAD_SD, CLS_DENORM, CLS_NORMAL, 8'h00, RESP_NORMALIZE, 8'h02);
      exf(OP_LOAD_EXT, CLS_DENORM, CLS_NORMAL, 8'h00, RESP_NONE, 8'h00);
      exf(OP_ARITH, CLS_SNAN, CLS_NORMAL, 8'h08, RESP_QNAN, 8'h09);
   endtask
   task s_unmasked;
      instr_addr <= 32'h0000_1230;
      oper_addr <= 32'h0000_4560;
      has_mem_oper <= 1'b1;
      swop(OFS_CONTROL, 32'h037e);
      ex(OP_ARITH, CLS_SNAN, CLS_NORMAL, 8'h00, RESP_TRAP);
      rdc(OFS_STATUS, 32'h0081);
      chk(error_n, 1'b0);
      rdc(OFS_INSTR_PTR, 32'h1230);
      rdc(OFS_DATA_PTR, 32'h4560);
      @(posedge hclk);
      issue <= 1'b1;
      @(posedge hclk);
      issue <= 1'b0;
      @(posedge hclk);
      chk({trap16, instr_valid}, 2'h2);
      swop(OFS_COMMAND, 32'h2);
      chk(error_n, 1'b1);
      swop(OFS_CONTROL, 32'h1f7b);
      chk(round_mode, RC_CHOP);
      ex(OP_ARITH, CLS_NORMAL, CLS_NORMAL, 8'h08, RESP_LARGEST);
      ex(OP_DIV, CLS_NORMAL, CLS_ZERO, 8'h00, RESP_TRAP);
      swop(OFS_COMMAND, 32'h1);
      rdc(OFS_CONTROL, 32'h037f);
      rdc(OFS_STATUS, 32'h0);
      rdc(OFS_TAG, 32'hffff);
      chk({error_n, round_mode, precision_ctrl}, 5'h13);
   endtask
   task s_tag_cc;
      tag_live <= 16'h5554;
      ahb(OFS_TAG, 1'b1, 32'h000f);
      rdc(OFS_TAG, 32'h555f);
      reg_written <= 8'h01;
      @(posedge hclk);
      reg_written <= 8'h00;
      rdc(OFS_TAG, 32'h555c);
      cc_in <= 4'hf;
      ex(OP_COMPARE, CLS_NORMAL, CLS_NORMAL, 8'h00, RESP_NONE);
      rdc(OFS_STATUS, 32'h4700);
      ex(OP_PREM, CLS_NORMAL, CLS_NORMAL, 8'h80, RESP_NONE);
      rdc(OFS_STATUS, 32'h0);
   endtask
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   initial begin
      #100000;
      n_errors++;
      stop_test;
   end
   initial begin
      {hsel, hwrite, issue, has_mem_oper, opa_sign, res_sign, hresetn} = '0;
      {stack_overflow, stack_underflow, indeterminate, res_too_big, res_tiny} = '0;
      {res_denorm_loses, res_inexact, prem_incomplete, htrans, top_in, cc_in} = '0;
      {reg_written, env_control, env_status, tag_live, haddr, hwdata} = '0;
      {instr_addr, oper_addr} = '0;
      hsize = 3'h2;
      instr_op = OP_ARITH;
      opa_class = CLS_NORMAL;
      opb_class = CLS_NORMAL;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      s_reset;
      s_masked;
      s_unmasked;
      s_tag_cc;
      stop_test;
   end
endmodule
`default_nettype wire
